// *** rtl/mms_pkg.sv ***
/*
  Constants and types for the two-wire management target.
  Assumes a single 50 MHz clock domain in which all link pins are sampled.
*/
package mms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte and address layout.
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  // The top address bit selects the lower or upper 128-byte area.
  localparam int unsigned AREA_BIT = 7;
  localparam logic [ADDR_W-1:0] PTR_RESET = 8'h00;

  // Control bytes that open a transaction.
  localparam logic [BYTE_W-1:0] CTRL_READ = 8'hA1;
  localparam logic [BYTE_W-1:0] CTRL_WRITE = 8'hA0;

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer geometry.
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_W = ADDR_W + BYTE_W;
  localparam logic [1:0] BUF_FULL = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Link engine states.
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_RX = 7'b000_0010,
    ST_DECIDE = 7'b000_0100,
    ST_ACK = 7'b000_1000,
    ST_TX = 7'b001_0000,
    ST_RACK = 7'b010_0000,
    ST_IGNORE = 7'b100_0000
  } mms_state_t;

  // Meaning of the byte being received.
  typedef enum logic [2:0] {
    KIND_CTRL = 3'b001,
    KIND_ADDR = 3'b010,
    KIND_DATA = 3'b100
  } mms_kind_t;

endpackage : mms_pkg

// *** rtl/mms_target.sv ***
/*
  Two-wire management target: control byte decoding, current byte address
  pointer with area roll-over, read byte shifting, ACK/NACK generation and a
  two-entry buffer of committed write bytes toward the memory.
  Assumes SCL, SDA and the select line arrive from outside the clock domain,
  that SDA is an open-drain wire resolved outside, and that the memory answers
  o_rd_addr combinationally on i_rd_data.
*/
// Behaviour
// - One current byte address pointer serves accesses that carry no address.
// - An explicit byte address in an access is loaded into the pointer.
// - Each byte read or written advances the pointer within its 128-byte area.
// - Lower area: incrementing 127 gives 0.
// - Upper area: incrementing 255 gives 128.
// - The pointer is kept between accesses while powered and no violation occurs.
// - Select asserted enables the management link; deasserted passivates it.
// - Initiator makes SCL; both sides sample SDA on SCL rising edges.
// - Data bits change SDA only while SCL is low.
// - SDA falling while SCL high is START; transactions open with it.
// - SDA rising while SCL high is STOP; regular transactions close with it.
// - Bytes are 8 bits, MSB first, low is 0 and high is 1.
// - First byte is control: A1 hex reads, A0 hex writes.
// - Transmitter releases SDA one bit time; receiver pulls low to ACK.
// - Target ACKs control bytes and every byte received in a write; the code NACKs data while the buffer is full and a byte is pending.
// - The serial interface enters idle at power-up.
// - A write's byte address loads the pointer at once, before data.
// - Repeated START instead of STOP drops pending data, pointer not incremented.
// - After an orderly STOP the pointer increments before the next transaction; the code defers it while the buffer is full and NACKs control bytes until then.
module mms_target
  import mms_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_module_select_line,
  output logic [ADDR_W-1:0] o_rd_addr,
  output logic o_rd_strobe,
  input wire logic [BYTE_W-1:0] i_rd_data,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [BYTE_W-1:0] o_wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  mms_state_t state_q;
  mms_kind_t kind_q;
  logic [BIT_CNT_W-1:0] cnt_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] rx_byte;
  logic byte_done;
  logic accept;
  logic ack_q;
  logic read_q;
  logic host_ack_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [BYTE_W-1:0] pend_data_q;
  logic pend_wr_q;
  logic commit_q;
  logic pend_inc_q;
  logic data_push;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_push;
  logic host_acked;
  logic load_tx;
  logic sda_oe_q;
  logic rd_strobe_q;
  logic [BUF_W-1:0] buf_q [BUF_DEPTH];
  logic buf_wr_idx_q;
  logic buf_rd_idx_q;
  logic [1:0] buf_cnt_q;

  // Increment inside the current 128-byte area; the area bit never changes.
  function automatic logic [ADDR_W-1:0] area_inc(input logic [ADDR_W-1:0] a);
    logic [AREA_BIT-1:0] low;
    low = a[AREA_BIT-1:0] + 7'h01;
    return {a[AREA_BIT], low};
  endfunction : area_inc

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync1_q <= {i_module_select_line, i_sda, i_scl};
      sync2_q <= sync1_q;
      scl_p_q <= sync2_q[0];
      sda_p_q <= sync2_q[1];
    end
  end

  // Edge and framing detection on the synchronised pins.
  assign scl_s = sync2_q[0];
  assign sda_s = sync2_q[1];
  assign sel_s = sync2_q[2];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = sel_s & scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = sel_s & scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Byte reception and the accept decision taken at the eighth bit.
  assign rx_byte = {shift_q[BYTE_W-2:0], sda_s};
  assign byte_done = (state_q == ST_RX) & scl_rise & (cnt_q == LAST_BIT);
  assign data_push = byte_done & (kind_q == KIND_DATA) & pend_wr_q & buf_in_ready;

  // A held-off write commit makes the next control byte go unanswered.
  always_comb begin
    unique case (kind_q)
      KIND_CTRL: accept = ((rx_byte == CTRL_READ) | (rx_byte == CTRL_WRITE)) & ~commit_q;
      KIND_ADDR: accept = 1'b1;
      KIND_DATA: accept = ~pend_wr_q | buf_in_ready;
      default: accept = 1'b0;
    endcase
  end

  assign host_acked = (state_q == ST_RACK) & scl_fall & host_ack_q;
  assign load_tx = ((state_q == ST_ACK) & scl_fall & read_q) | host_acked;

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine; framing wins at any bit position.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      kind_q <= KIND_CTRL;
      cnt_q <= '0;
      shift_q <= '0;
      ack_q <= 1'b0;
      read_q <= 1'b0;
      host_ack_q <= 1'b0;
    end else if (!sel_s) begin
      state_q <= ST_IDLE;
    end else if (start_ev) begin
      state_q <= ST_RX;
      kind_q <= KIND_CTRL;
      cnt_q <= '0;
    end else if (stop_ev) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_RX: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == LAST_BIT) begin
              ack_q <= accept;
              state_q <= ST_DECIDE;
              if (kind_q == KIND_CTRL) begin
                read_q <= rx_byte[0];
              end
            end
          end
        end
        ST_DECIDE: begin
          if (scl_fall) begin
            state_q <= ack_q ? ST_ACK : ST_IGNORE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_q <= '0;
            if (read_q) begin
              state_q <= ST_TX;
              shift_q <= i_rd_data;
            end else begin
              state_q <= ST_RX;
              kind_q <= (kind_q == KIND_CTRL) ? KIND_ADDR : KIND_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 3'h1;
          end else if (scl_fall) begin
            shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
            if (cnt_q == '0) begin
              state_q <= ST_RACK;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            host_ack_q <= ~sda_s;
          end else if (scl_fall) begin
            if (host_ack_q) begin
              state_q <= ST_TX;
              shift_q <= i_rd_data;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_IGNORE: state_q <= ST_IGNORE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive: open drain, pulled low only for ACK or a zero read bit.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sda_oe_q <= 1'b0;
    end else if (!sel_s | start_ev | stop_ev) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      if (state_q == ST_DECIDE) begin
        sda_oe_q <= ack_q;
      end else if (load_tx) begin
        sda_oe_q <= ~i_rd_data[BYTE_W-1];
      end else if ((state_q == ST_TX) & (cnt_q != '0)) begin
        sda_oe_q <= ~shift_q[BYTE_W-2];
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_q;

  // Read strobe is registered: it marks the cycle after the one in which a read byte is taken from memory.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_strobe_q <= 1'b0;
    end else begin
      rd_strobe_q <= sel_s & ~start_ev & ~stop_ev & load_tx;
    end
  end

  assign o_rd_strobe = rd_strobe_q;
  assign o_rd_addr = ptr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pending write byte and deferred increments.
  // A data byte waits until the next byte or STOP proves it was not aborted.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_wr_q <= 1'b0;
      pend_data_q <= '0;
      commit_q <= 1'b0;
      pend_inc_q <= 1'b0;
    end else begin
      if (buf_push & commit_q) begin
        pend_wr_q <= 1'b0;
        commit_q <= 1'b0;
      end else if (start_ev & ~commit_q) begin
        pend_wr_q <= 1'b0;
      end else if (stop_ev & pend_wr_q) begin
        commit_q <= 1'b1;
      end else if (byte_done & (kind_q == KIND_DATA) & accept) begin
        pend_wr_q <= 1'b1;
        pend_data_q <= rx_byte;
      end
      // A NACKed final read byte is counted when STOP arrives.
      if (start_ev | stop_ev) begin
        pend_inc_q <= 1'b0;
      end else if ((state_q == ST_RACK) & scl_fall & ~host_ack_q) begin
        pend_inc_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current byte address pointer; kept across select and idle periods.
  // A host ACK advances it on the ACK bit's rising edge, so that the next read byte
  // is fetched at the new address on the following fall rather than at the old one.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ptr_q <= PTR_RESET;
    end else if (buf_push) begin
      ptr_q <= area_inc(ptr_q);
    end else if (stop_ev & pend_inc_q) begin
      ptr_q <= area_inc(ptr_q);
    end else if (sel_s & (state_q == ST_RACK) & scl_rise & ~sda_s) begin
      ptr_q <= area_inc(ptr_q);
    end else if (byte_done & (kind_q == KIND_ADDR)) begin
      ptr_q <= rx_byte;
    end else begin
      ptr_q <= ptr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry write buffer toward the memory; a full buffer NACKs new data while a byte is pending.
  assign buf_in_valid = (pend_wr_q & commit_q) | data_push;
  assign buf_in_ready = (buf_cnt_q != BUF_FULL);
  assign buf_push = buf_in_valid & buf_in_ready;
  assign o_wr_valid = (buf_cnt_q != 2'h0);
  assign o_wr_addr = buf_q[buf_rd_idx_q][BUF_W-1:BYTE_W];
  assign o_wr_data = buf_q[buf_rd_idx_q][BYTE_W-1:0];

  // Entry storage, one flop group per slot.
  for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_buf
    always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
        buf_q[e] <= '0;
      end else if (buf_push & (buf_wr_idx_q == 1'(e))) begin
        buf_q[e] <= {ptr_q, pend_data_q};
      end
    end
  end

  // Buffer pointers and fill count.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      buf_wr_idx_q <= 1'b0;
      buf_rd_idx_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_wr_idx_q <= ~buf_wr_idx_q;
      end
      if (o_wr_valid & i_wr_ready) begin
        buf_rd_idx_q <= ~buf_rd_idx_q;
      end
      unique case ({buf_push, o_wr_valid & i_wr_ready})
        2'b10: buf_cnt_q <= buf_cnt_q + 2'h1;
        2'b01: buf_cnt_q <= buf_cnt_q - 2'h1;
        default: buf_cnt_q <= buf_cnt_q;
      endcase
    end
  end

endmodule : mms_target

// *** dv/mms_target_chk.sv ***
/*
  Pin assertions for the two-wire management target.
  Assumes binding to mms_target inside its single clock domain.
*/
module mms_target_chk
  import mms_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_module_select_line,
  input wire logic [ADDR_W-1:0] o_rd_addr,
  input wire logic o_wr_valid,
  input wire logic i_wr_ready,
  input wire logic [ADDR_W-1:0] o_wr_addr,
  input wire logic [BYTE_W-1:0] o_wr_data
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////
  // Select held low long enough to pass the synchronisers.
  sequence s_unsel;
    (!i_module_select_line) [*4];
  endsequence
  // A clock parked high this long only happens outside frames.
  sequence s_parked;
    i_scl [*8];
  endsequence
  // Relations between the link pins and the engine outputs.
  chk_reset_idle: assert property ($rose(i_rst_b) |-> !o_sda_oe && !o_wr_valid && o_rd_addr == PTR_RESET)
    else $error("link not idle after reset");
  chk_sda_low_only: assert property (o_sda_oe |-> o_sda_o == 1'b0)
    else $error("SDA driven high");
  chk_oe_after_fall: assert property ($rose(o_sda_oe) |-> !$past(i_scl, 3))
    else $error("SDA pulled without a clock fall");
  chk_oe_stands: assert property ($rose(o_sda_oe) |-> o_sda_oe [*5])
    else $error("SDA pull cut short");
  chk_unsel_release: assert property (s_unsel |-> !o_sda_oe)
    else $error("SDA pulled while unselected");
  chk_unsel_ptr: assert property (s_unsel |=> $stable(o_rd_addr))
    else $error("pointer moved while unselected");
  chk_parked_idle: assert property (s_parked |-> !o_sda_oe)
    else $error("SDA pulled outside a frame");
  chk_wr_hold: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
    else $error("stalled write entry changed");
endmodule : mms_target_chk

bind mms_target mms_target_chk u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .i_module_select_line(i_module_select_line), .o_rd_addr(o_rd_addr), .o_wr_valid(o_wr_valid),
  .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data)
);

// *** dv/mms_host_model.sv ***
/*
  Host initiator model: makes SCL and drives SDA open-drain.
  Assumes a pull-up on SDA and the bench clock as its time base.
*/
module mms_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines released; the clock stands still outside frames.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  ////////////////////////////////////////
  // One bit: SDA moves only while SCL is low, taken on the rise.
  // The bit time is scaled down for run time; the target relies only on edge order.
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    repeat (2) @(posedge i_clk);
    o_scl <= 1'b1;
    repeat (2) @(posedge i_clk);
    r = i_sda;
    repeat (2) @(posedge i_clk);
    o_scl <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : bit_io
  // Waits longer before the rise so a late ACK release cannot fake a STOP.
  task automatic start();
    o_sda <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_sda <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_scl <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : start
  // Closes the frame and leaves time for the pointer update.
  task automatic stop();
    o_sda <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_sda <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask : stop
  // Sends a byte MSB first and returns the target's answer.
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_tx
  // Reads a byte, then answers ACK or, on the last byte, NACK.
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : byte_rx
endmodule : mms_host_model

// *** dv/tb.sv ***
/*
  Bench for the management target with a host model and a byte memory.
  Assumes memory data equals the address XOR C3 hex and an SDA pull-up.
*/
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb
  import mms_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel = 1'b1;
  logic rdy = 1'b0;
  logic scl, host_sda, oe, a, wr_valid;
  logic rd_stb;
  int strobes = 0;
  logic [7:0] d, rd_addr, wr_addr, wr_data;
  logic [15:0] wq[$];
  int fails = 0;
  int checked = 0;
  // Open-drain wire: low while either side pulls.
  wire logic sda = host_sda & ~oe;
  wire logic [7:0] rd_data = rd_addr ^ 8'hC3;
  always #10 clk = ~clk;
  // The memory side takes an entry on valid and ready.
  always @(posedge clk) if (wr_valid && rdy) wq.push_back({wr_addr, wr_data});
  // Every byte fetched from memory shows one read strobe.
  always @(posedge clk) if (rd_stb) strobes++;
  mms_target u_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .o_sda_o(), .o_sda_oe(oe),
    .i_module_select_line(sel), .o_rd_addr(rd_addr), .o_rd_strobe(rd_stb), .i_rd_data(rd_data),
    .o_wr_valid(wr_valid), .i_wr_ready(rdy), .o_wr_addr(wr_addr), .o_wr_data(wr_data)
  );
  mms_host_model u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
  ////////////////////////////////////////
  task automatic close_out;
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // Byte to the target with its expected answer.
  task automatic wr(input logic [7:0] b, input logic ack);
    u_host.byte_tx(b, a);
    `CHK("ack", ack, a)
  endtask : wr
  // Byte from the target, expected from the memory at that address.
  task automatic rd(input logic last, input logic [7:0] at);
    u_host.byte_rx(last, d);
    `CHK("rdata", at ^ 8'hC3, d)
  endtask : rd
  // Bounded wait for n committed writes; a shortfall ends the run.
  task automatic drain(input int n);
    for (int i = 0; i < 400 && wq.size() < n; i++) @(posedge clk);
    `CHK("wcount", n, wq.size())
    if (wq.size() < n) close_out;
  endtask : drain
  // Current address read straight after reset.
  task automatic t_reset;
    `CHK("ptr", PTR_RESET, rd_addr)
    u_host.start();
    wr(CTRL_READ, 1'b1);
    rd(1'b1, 8'h00);
    u_host.stop();
    `CHK("ptr", 8'h01, rd_addr)
  endtask : t_reset
  // Fill the stalled buffer until a byte is refused, then drain it.
  task automatic t_fill;
    rdy <= 1'b0;
    u_host.start();
    wr(CTRL_WRITE, 1'b1);
    wr(8'h7E, 1'b1);
    `CHK("ptr", 8'h7E, rd_addr)
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    wr(8'h33, 1'b1);
    wr(8'h44, 1'b0);
    u_host.stop();
    u_host.start();
    wr(CTRL_WRITE, 1'b0);
    u_host.stop();
    rdy <= 1'b1;
    drain(3);
    `CHK("w0", 16'h7E11, wq.pop_front())
    `CHK("w1", 16'h7F22, wq.pop_front())
    `CHK("w2", 16'h0033, wq.pop_front())
    `CHK("ptr", 8'h01, rd_addr)
  endtask : t_fill
  // Upper area roll-over, then a two-byte read from the pointer.
  task automatic t_upper;
    int s0;
    u_host.start();
    wr(CTRL_WRITE, 1'b1);
    wr(8'hFF, 1'b1);
    wr(8'h5A, 1'b1);
    wr(8'h6B, 1'b1);
    u_host.stop();
    drain(2);
    `CHK("w0", 16'hFF5A, wq.pop_front())
    `CHK("w1", 16'h806B, wq.pop_front())
    s0 = strobes;
    u_host.start();
    wr(CTRL_READ, 1'b1);
    rd(1'b0, 8'h81);
    rd(1'b1, 8'h82);
    u_host.stop();
    `CHK("ptr", 8'h83, rd_addr)
    `CHK("strobes", 2, strobes - s0)
  endtask : t_upper
  // Random read through an aborted write, then a START in mid-byte.
  task automatic t_random;
    u_host.start();
    wr(CTRL_WRITE, 1'b1);
    wr(8'h7F, 1'b1);
    wr(8'h99, 1'b1);
    u_host.start();
    wr(CTRL_READ, 1'b1);
    rd(1'b0, 8'h7F);
    rd(1'b1, 8'h00);
    u_host.stop();
    `CHK("dropped", 0, wq.size())
    u_host.start();
    u_host.bit_io(1'b1, a);
    u_host.bit_io(1'b0, a);
    u_host.start();
    wr(CTRL_READ, 1'b1);
    rd(1'b1, 8'h01);
    u_host.stop();
  endtask : t_random
  // Unknown control byte, then traffic while deselected.
  task automatic t_bad;
    u_host.start();
    wr(8'hA2, 1'b0);
    u_host.stop();
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    u_host.start();
    wr(CTRL_WRITE, 1'b0);
    u_host.stop();
    sel <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("ptr", 8'h02, rd_addr)
  endtask : t_bad
  // Host loses track in a read of byte 7F hex; clocking frees SDA after two cycles.
  task automatic t_recover;
    int n;
    logic r;
    u_host.start();
    wr(CTRL_WRITE, 1'b1);
    wr(8'hBC, 1'b1);
    u_host.start();
    wr(CTRL_READ, 1'b1);
    r = 1'b0;
    n = 0;
    for (int i = 0; i < 9 && !r; i++) begin
      u_host.bit_io(1'b1, r);
      n++;
    end
    `CHK("released", 1'b1, r)
    `CHK("rcycles", 2, n)
    u_host.stop();
    `CHK("ptr", 8'hBC, rd_addr)
    u_host.start();
    wr(CTRL_WRITE, 1'b1);
    wr(8'h10, 1'b1);
    u_host.start();
    wr(CTRL_READ, 1'b1);
    rd(1'b1, 8'h10);
    u_host.stop();
    `CHK("ptr", 8'h11, rd_addr)
  endtask : t_recover
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_fill;
    t_upper;
    t_random;
    t_bad;
    t_recover;
    close_out;
  end
endmodule : tb
